// file: rtl/display_pkg.sv
// constants, types and encodings for the incremental display word interpreter
package display_pkg;
   localparam int WORD_W     = 36;
   localparam int HALF_W     = 18;
   localparam int POS_W      = 10;
   localparam int CLK_MHZ    = 200;
   // times in nanoseconds
   localparam int SETTLE_NS  = 30000;
   localparam int STEP_NS    = 1500;
   localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int STEP_CYC   = (STEP_NS * CLK_MHZ + 999) / 1000;
   // control word bit positions, bit 0 is the leftmost (msb) of a half word
   localparam int B_ESC      = 0;
   localparam int B_AXIS     = 1;
   localparam int B_MODE0    = 2;
   localparam int B_PEN_CHG  = 5;
   localparam int B_PEN      = 6;
   localparam int B_INT      = 7;
   localparam int B_STOP_IRQ = 8;
   localparam int B_POS0     = 8;
   localparam int B_SCL_CHG  = 11;
   localparam int B_SCL0     = 12;
   localparam int B_LVL_CHG  = 14;
   localparam int B_LVL0     = 15;
   localparam int B_STEP0    = 2;
   localparam int B_DX0      = 2;
   localparam int B_DY0      = 10;
   localparam int CHAR_W     = 6;
   localparam int CHARS      = 6;
   localparam logic [2:0] MODE_PARAM = 3'h0;
   localparam logic [2:0] MODE_POINT = 3'h1;
   localparam logic [2:0] MODE_INCR  = 3'h2;
   localparam logic [2:0] MODE_VEC   = 3'h3;
   localparam logic [2:0] MODE_VCONT = 3'h4;
   localparam logic [2:0] MODE_CHAR  = 3'h5;
   localparam logic [5:0] CH_ESC     = 6'h3f;
   localparam logic [5:0] CH_SPACE   = 6'h00;
   localparam logic [5:0] CH_CR      = 6'h3e;
   localparam logic [5:0] CH_UPPER   = 6'h3c;
   localparam logic [5:0] CH_LOWER   = 6'h3d;
   localparam logic [POS_W-1:0] CHAR_ADV = 10'h008;

   typedef struct packed {
      logic             done;
      logic             pen;
      logic             edge_hit;
      logic             stop;
   } flags_t;

   typedef struct packed {
      logic [POS_W-1:0] x;
      logic [POS_W-1:0] y;
      logic [2:0]       level;
      logic [1:0]       scale;
      logic             beam;
   } spot_t;
endpackage

// file: rtl/incremental_display_word_interpreter.sv
// interprets host words into spot moves, plots and interrupt requests
`timescale 1ns/1ps
// Operation
// - done requests on data channel; pen, edge, stop on special channel
// - pen flag sets when pen enabled and a plotted spot is sensed
// - host writes control bit 29 to reinitialize after special interrupt
// - each 36-bit word splits in two halves, left processed first
// - x-y word bit 1 picks axis; bits 8-17 give position
// - mode bits 2-4 latched; data words use mode until escape
// - bit 5 set loads pen enable from bit 6
// - x-y intensify bit 7 plots one point, otherwise just moves
// - parameter bit 7 halts display, sets stop, inhibits data requests
// - parameter stop interrupts only when bit 8 of stopping word is one; edge stops always interrupt
// - scale bits 12-13 load only when bit 11 is one
// - intensity bits 15-17 load only when bit 14 is one
// - each new point waits 30 us settling before plotting and accepting
// - increment word gives four steps, 1.5 us each
// - all-zero step code neither moves nor plots
// - increment bit 1 zero moves without intensifying
// - escape bit 0 finishes word then returns to parameter mode
// - vector continue runs to screen edge, escapes, requests data
// - each plotted point advances position by two to the scale
// - edge sets flag and escapes; illegal edge also stops; new data clears
// - vector deltas are sign plus seven bits on 1024 grid, 1.5 us per point
// - character mode unpacks six 6-bit codes with shift, space, cr, escape
module incremental_display_word_interpreter
   import display_pkg::*;
#(
   parameter int          SETTLE_CYCLES = SETTLE_CYC,
   parameter logic [2:0]  M_PARAM       = MODE_PARAM,
   parameter logic [2:0]  M_POINT       = MODE_POINT,
   parameter logic [2:0]  M_INCR        = MODE_INCR,
   parameter logic [2:0]  M_VEC         = MODE_VEC,
   parameter logic [2:0]  M_VCONT       = MODE_VCONT,
   parameter logic [2:0]  M_CHAR        = MODE_CHAR
)
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              clk_en,
   input  wire logic [WORD_W-1:0] host_data,
   input  wire logic              host_valid,
   input  wire logic              reinit,
   input  wire logic              flag_clear,
   input  wire logic              pen_sense,
   output logic                   data_request,
   output logic                   data_irq,
   output logic                   special_irq,
   output flags_t                 flags,
   output spot_t                  spot,
   output logic                   pen_enable,
   output logic                   upper_case,
   output logic [CHAR_W-1:0]      char_code,
   output logic                   char_strobe
);
   localparam int CW = $clog2((SETTLE_CYCLES > STEP_CYC ? SETTLE_CYCLES : STEP_CYC) + 1);

   typedef enum {ST_IDLE, ST_DECODE, ST_SETTLE, ST_INCR, ST_VEC, ST_CHAR, ST_NEXT, ST_HALT} state_t;
   state_t            state_reg;
   logic [WORD_W-1:0] word_reg;
   logic              half_reg;
   logic [2:0]        mode_reg;
   logic [CW-1:0]     timer_reg;
   logic [2:0]        sub_reg;
   logic              stop_irq_en_reg;
   logic              plot_pending_reg;
   logic              esc_reg;
   logic [6:0]        vx_left_reg;
   logic [6:0]        vy_left_reg;
   logic [7:0]        vec_span_reg;
   logic              pen_meta_reg;
   logic              pen_sync1_reg;
   logic              pen_sync2_reg;

   // bit n counted from the left of an 18-bit half
   function automatic logic hb(input logic [HALF_W-1:0] h, input int n);
      hb = h[HALF_W-1-n];
   endfunction
   function automatic logic [HALF_W-1:0] half_sel(input logic [WORD_W-1:0] w, input logic right);
      half_sel = right ? w[HALF_W-1:0] : w[WORD_W-1:HALF_W];
   endfunction
   function automatic logic [CW-1:0] step_time();
      step_time = CW'(STEP_CYC);
   endfunction

   logic [HALF_W-1:0] cur;
   logic [3:0]        step_code;
   logic [CHAR_W-1:0] cur_char;
   logic [POS_W-1:0]  inc;
   logic signed [POS_W+1:0] nx;
   logic signed [POS_W+1:0] ny;
   logic              dx_move;
   logic              dy_move;
   logic              dx_neg;
   logic              dy_neg;
   logic              step_off;
   logic              tick;

   always_comb
   begin
      cur       = half_sel(word_reg, half_reg);
      step_code = cur[HALF_W-1-B_STEP0-4*sub_reg[1:0] -: 4];
      cur_char  = word_reg[WORD_W-1-CHAR_W*sub_reg -: CHAR_W];
      inc       = POS_W'(1) << spot.scale;
      tick      = (timer_reg == '0);
      dx_move   = 1'b0;
      dy_move   = 1'b0;
      dx_neg    = 1'b0;
      dy_neg    = 1'b0;
      if (state_reg == ST_INCR)
      begin
         // code: bit0 x move, bit1 x sign, bit2 y move, bit3 y sign
         dx_move = step_code[3];
         dx_neg  = step_code[2];
         dy_move = step_code[1];
         dy_neg  = step_code[0];
      end
      else if (state_reg == ST_VEC)
      begin
         // steps for the largest delta, each axis until its own count runs out; continue mode runs on until the edge
         dx_move = (vx_left_reg != '0) || (mode_reg == M_VCONT && hb(cur, B_DX0+1) | (cur[HALF_W-1-B_DX0-1 -: 7] != '0));
         dy_move = (vy_left_reg != '0) || (mode_reg == M_VCONT && (cur[HALF_W-1-B_DY0-1 -: 7] != '0));
         dx_neg  = hb(cur, B_DX0);
         dy_neg  = hb(cur, B_DY0);
      end
      nx = $signed({2'b00, spot.x}) + (dx_move ? (dx_neg ? -$signed({2'b00, inc}) : $signed({2'b00, inc})) : '0);
      ny = $signed({2'b00, spot.y}) + (dy_move ? (dy_neg ? -$signed({2'b00, inc}) : $signed({2'b00, inc})) : '0);
      step_off = (nx < 0) || (nx > $signed(12'h3ff)) || (ny < 0) || (ny > $signed(12'h3ff));
   end

   // pen sense from the tube comes asynchronously
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         pen_meta_reg  <= 1'b0;
         pen_sync1_reg <= 1'b0;
         pen_sync2_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         pen_meta_reg  <= pen_sense;
         pen_sync1_reg <= pen_meta_reg;
         pen_sync2_reg <= pen_sync1_reg;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst || (clk_en && reinit))
      begin
         state_reg        <= ST_IDLE;
         word_reg         <= '0;
         half_reg         <= 1'b0;
         mode_reg         <= M_PARAM;
         timer_reg        <= '0;
         sub_reg          <= '0;
         stop_irq_en_reg  <= 1'b0;
         plot_pending_reg <= 1'b0;
         esc_reg          <= 1'b0;
         vx_left_reg      <= '0;
         vy_left_reg      <= '0;
         vec_span_reg     <= '0;
         data_request     <= 1'b1;
         flags            <= '0;
         spot             <= '0;
         pen_enable       <= 1'b0;
         upper_case       <= 1'b0;
         char_code        <= '0;
         char_strobe      <= 1'b0;
      end
      else if (clk_en)
      begin
         char_strobe <= 1'b0;
         spot.beam   <= 1'b0;
         if (!tick)
            timer_reg <= timer_reg - CW'(1);
         if (flag_clear)
            flags <= '0;
         if (pen_enable && spot.beam && pen_sync2_reg && pen_sync1_reg)
            flags.pen <= 1'b1;
         case (state_reg)
            ST_IDLE:
               if (host_valid)
               begin
                  word_reg        <= host_data;
                  half_reg        <= 1'b0;
                  data_request    <= 1'b0;
                  flags.done      <= 1'b0;
                  flags.edge_hit  <= 1'b0;
                  sub_reg         <= '0;
                  state_reg       <= (mode_reg == M_CHAR) ? ST_CHAR : ST_DECODE;
               end
            ST_DECODE:
            begin
               sub_reg <= '0;
               esc_reg <= hb(cur, B_ESC);
               if (mode_reg == M_PARAM || mode_reg == M_POINT)
               begin
                  mode_reg <= cur[HALF_W-1-B_MODE0 -: 3];
                  if (hb(cur, B_PEN_CHG))
                     pen_enable <= hb(cur, B_PEN);
                  if (mode_reg == M_POINT)
                  begin
                     if (hb(cur, B_AXIS))
                        spot.y <= cur[POS_W-1:0];
                     else
                        spot.x <= cur[POS_W-1:0];
                     plot_pending_reg <= hb(cur, B_INT);
                     timer_reg        <= CW'(SETTLE_CYCLES);
                     state_reg        <= ST_SETTLE;
                  end
                  else
                  begin
                     if (hb(cur, B_SCL_CHG))
                        spot.scale <= cur[HALF_W-1-B_SCL0 -: 2];
                     if (hb(cur, B_LVL_CHG))
                        spot.level <= cur[HALF_W-1-B_LVL0 -: 3];
                     if (hb(cur, B_INT))
                     begin
                        flags.stop      <= 1'b1;
                        stop_irq_en_reg <= hb(cur, B_STOP_IRQ);
                        state_reg       <= ST_HALT;
                     end
                     else
                        state_reg <= ST_NEXT;
                  end
               end
               else if (mode_reg == M_INCR)
               begin
                  timer_reg <= step_time();
                  state_reg <= ST_INCR;
               end
               else
               begin
                  vx_left_reg  <= cur[HALF_W-1-B_DX0-1 -: 7];
                  vy_left_reg  <= cur[HALF_W-1-B_DY0-1 -: 7];
                  vec_span_reg <= {1'b0, (cur[HALF_W-1-B_DX0-1 -: 7] > cur[HALF_W-1-B_DY0-1 -: 7]) ?
                                  cur[HALF_W-1-B_DX0-1 -: 7] : cur[HALF_W-1-B_DY0-1 -: 7]};
                  timer_reg    <= step_time();
                  state_reg    <= ST_VEC;
               end
            end
            ST_SETTLE:
               if (tick)
               begin
                  spot.beam <= plot_pending_reg;
                  state_reg <= ST_NEXT;
               end
            ST_INCR:
               if (tick)
               begin
                  if (step_code != 4'h0)
                  begin
                     if (step_off)
                     begin
                        flags.edge_hit <= 1'b1;
                        flags.stop     <= 1'b1;
                        stop_irq_en_reg <= 1'b1;
                        mode_reg       <= M_PARAM;
                        state_reg      <= ST_HALT;
                     end
                     else
                     begin
                        spot.x    <= nx[POS_W-1:0];
                        spot.y    <= ny[POS_W-1:0];
                        spot.beam <= hb(cur, B_AXIS);
                     end
                  end
                  if (!step_off || step_code == 4'h0)
                  begin
                     sub_reg   <= sub_reg + 3'h1;
                     timer_reg <= step_time();
                     if (sub_reg == 3'h3)
                     begin
                        if (esc_reg)
                           mode_reg <= M_PARAM;
                        state_reg <= ST_NEXT;
                     end
                  end
               end
            ST_VEC:
               if (tick)
               begin
                  if (step_off || (vec_span_reg == '0 && mode_reg != M_VCONT))
                  begin
                     if (step_off)
                     begin
                        flags.edge_hit <= 1'b1;
                        if (mode_reg != M_VCONT)
                        begin
                           flags.stop      <= 1'b1;
                           stop_irq_en_reg <= 1'b1;
                           mode_reg        <= M_PARAM;
                           state_reg       <= ST_HALT;
                        end
                        else
                        begin
                           mode_reg  <= M_PARAM;
                           state_reg <= ST_NEXT;
                        end
                     end
                     else
                     begin
                        if (esc_reg)
                           mode_reg <= M_PARAM;
                        state_reg <= ST_NEXT;
                     end
                  end
                  else
                  begin
                     spot.x       <= nx[POS_W-1:0];
                     spot.y       <= ny[POS_W-1:0];
                     spot.beam    <= hb(cur, B_AXIS);
                     vec_span_reg <= vec_span_reg - 8'h01;
                     if (vx_left_reg != '0)
                        vx_left_reg <= vx_left_reg - 7'h01;
                     if (vy_left_reg != '0)
                        vy_left_reg <= vy_left_reg - 7'h01;
                     timer_reg    <= step_time();
                  end
               end
            ST_CHAR:
               if (tick)
               begin
                  timer_reg <= step_time();
                  sub_reg   <= sub_reg + 3'h1;
                  if (cur_char == CH_ESC)
                  begin
                     mode_reg  <= M_PARAM;
                     half_reg  <= 1'b1;
                     state_reg <= ST_NEXT;
                  end
                  else
                  begin
                     if (cur_char == CH_UPPER)
                        upper_case <= 1'b1;
                     else if (cur_char == CH_LOWER)
                        upper_case <= 1'b0;
                     else if (cur_char == CH_CR)
                        spot.x <= '0;
                     else
                     begin
                        spot.x      <= spot.x + (CHAR_ADV << spot.scale);
                        char_code   <= cur_char;
                        char_strobe <= (cur_char != CH_SPACE);
                     end
                     if (sub_reg == 3'(CHARS - 1))
                     begin
                        half_reg  <= 1'b1;
                        state_reg <= ST_NEXT;
                     end
                  end
               end
            ST_NEXT:
               if (!half_reg)
               begin
                  half_reg  <= 1'b1;
                  state_reg <= ST_DECODE;
               end
               else
               begin
                  flags.done   <= 1'b1;
                  data_request <= 1'b1;
                  state_reg    <= ST_IDLE;
               end
            ST_HALT:
               data_request <= 1'b0;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   // two channels, stop interrupt gated by its enable
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         data_irq    <= 1'b0;
         special_irq <= 1'b0;
      end
      else if (clk_en)
      begin
         data_irq    <= flags.done;
         special_irq <= flags.pen | flags.edge_hit | (flags.stop & stop_irq_en_reg);
      end
   end
endmodule

// file: bench/display_interp_properties.sv
// port-level assertions for the display word interpreter
`timescale 1ns/1ps
module display_interp_properties
   import display_pkg::*;
#(
   parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
   input wire logic              ref_clk,
   input wire logic              srst,
   input wire logic              clk_en,
   input wire logic [WORD_W-1:0] host_data,
   input wire logic              host_valid,
   input wire logic              reinit,
   input wire logic              flag_clear,
   input wire logic              pen_sense,
   input wire logic              data_request,
   input wire logic              data_irq,
   input wire logic              special_irq,
   input wire flags_t            flags,
   input wire spot_t             spot,
   input wire logic              pen_enable,
   input wire logic              upper_case,
   input wire logic [CHAR_W-1:0] char_code,
   input wire logic              char_strobe
);
   // point plots may follow a short settle, so the smaller spacing bounds them
   localparam int GAP_MIN = (SETTLE_CYCLES < STEP_CYC ? SETTLE_CYCLES : STEP_CYC) - 1;
   logic take;
   int   gap_reg;
   assign take = clk_en && host_valid && data_request && !reinit;
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         gap_reg <= 100000;
      else if (spot.beam)
         gap_reg <= 0;
      else if (gap_reg < 100000)
         gap_reg <= gap_reg + 1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   AST_TAKE_HALVES: assert property (take |=> !data_request [*3])
      else $error("request back before both halves");
   AST_DONE_IRQ: assert property (clk_en && !reinit |=> data_irq == $past(flags.done))
      else $error("data irq does not follow done");
   AST_SPECIAL_FLAGS: assert property ((flags.pen || flags.edge_hit) |-> ##[0:1] special_irq)
      else $error("special irq missing");
   AST_STOP_HALT: assert property (flags.stop |-> !data_request)
      else $error("request while stopped");
   AST_STOP_FROZEN: assert property (flags.stop && !reinit |=> $stable(spot.x) && $stable(spot.y))
      else $error("spot moved while stopped");
   AST_REQ_DONE: assert property ($rose(data_request) && !$past(reinit) |-> flags.done)
      else $error("request without done");
   AST_PEN_GATE: assert property (!pen_enable && !flags.pen |=> !flags.pen)
      else $error("pen flag while disabled");
   AST_BEAM_PULSE: assert property (spot.beam |=> !spot.beam)
      else $error("beam longer than one cycle");
   AST_BEAM_GAP: assert property (spot.beam |-> gap_reg >= GAP_MIN)
      else $error("plots too close");
   AST_CHAR_PULSE: assert property (char_strobe |=> !char_strobe)
      else $error("char strobe too long");
   cover property (spot.beam);
   cover property (char_strobe);
   cover property (flags.stop && special_irq);
   cover property (flags.edge_hit && data_request);
endmodule

bind incremental_display_word_interpreter display_interp_properties #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_props (
   .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .host_data(host_data), .host_valid(host_valid),
   .reinit(reinit), .flag_clear(flag_clear), .pen_sense(pen_sense), .data_request(data_request),
   .data_irq(data_irq), .special_irq(special_irq), .flags(flags), .spot(spot), .pen_enable(pen_enable),
   .upper_case(upper_case), .char_code(char_code), .char_strobe(char_strobe));

// file: bench/host_port_model.sv
// host side of the word interface: offers words and writes reinit
`timescale 1ns/1ps
module host_port_model
   import display_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              data_request,
   output logic                   host_valid,
   output logic [WORD_W-1:0]      host_data,
   output logic                   reinit
);
   initial
   begin
      host_valid = 1'b0;
      host_data  = '0;
      reinit     = 1'b0;
   end
   task automatic send(input logic [WORD_W-1:0] w);
      host_valid <= 1'b1;
      host_data  <= w;
      @(posedge ref_clk);
      while (data_request !== 1'b1)
         @(posedge ref_clk);
      host_valid <= 1'b0;
      // released bus must not look like a held word
      host_data  <= ~w;
   endtask
   task automatic pulse_reinit();
      reinit <= 1'b1;
      @(posedge ref_clk);
      reinit <= 1'b0;
   endtask
endmodule

// file: bench/incremental_display_word_interpreter_test.sv
// self-checking bench for the display word interpreter
`timescale 1ns/1ps
module incremental_display_word_interpreter_test
   import display_pkg::*;
;
   localparam int SET   = 20;
   localparam int LIMIT = 20000;
   logic              ref_clk, srst, clk_en, host_valid, reinit, flag_clear, pen_sense, watch;
   logic              data_request, data_irq, special_irq, pen_enable, upper_case, char_strobe;
   logic [WORD_W-1:0] host_data;
   logic [CHAR_W-1:0] char_code;
   flags_t            flags;
   spot_t             spot;
   int                err_total = 0, checks_done = 0, cycles = 0, lat, sc, lv;
   logic [19:0]       exp_plot[$];
   logic [5:0]        exp_char[$];

   incremental_display_word_interpreter #(.SETTLE_CYCLES(SET)) i_incremental_display_word_interpreter (
      .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .host_data(host_data), .host_valid(host_valid),
      .reinit(reinit), .flag_clear(flag_clear), .pen_sense(pen_sense), .data_request(data_request),
      .data_irq(data_irq), .special_irq(special_irq), .flags(flags), .spot(spot), .pen_enable(pen_enable),
      .upper_case(upper_case), .char_code(char_code), .char_strobe(char_strobe));
   host_port_model i_host_port_model (.ref_clk(ref_clk), .data_request(data_request),
      .host_valid(host_valid), .host_data(host_data), .reinit(reinit));

   initial
   begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   function automatic logic [17:0] fld(input int v, input int hi);
      return 18'(v) << (17 - hi);
   endfunction
   function automatic logic [17:0] b(input int k);
      return 18'h20000 >> k;
   endfunction
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic cmp_val(input string nm, input logic [19:0] e, input logic [19:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_plot(input logic [19:0] e, input logic [9:0] x, input logic [9:0] y);
      cmp_val("plot", e, {x, y});
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // returns once the device asks for the next word
   task automatic run(input logic [17:0] l, input logic [17:0] r);
      i_host_port_model.send({l, r});
      lat = 0;
      do
      begin
         @(posedge ref_clk);
         lat++;
      end
      while (data_request !== 1'b1);
   endtask
   task automatic wait_stop();
      repeat (3000) if (flags.stop !== 1'b1) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
   endtask
   task automatic reinit_check();
      i_host_port_model.pulse_reinit();
      @(posedge ref_clk);
      cmp_bit("reinit request", 1'b1, data_request);
      cmp_val("reinit flags", 20'h0, 20'(flags));
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         err_total++;
         $display("Error timeout expected %0d seen %0d", LIMIT - 1, cycles);
         complete_run();
      end
   end

   always @(posedge ref_clk)
   begin
      if (watch && spot.beam === 1'b1)
         cmp_plot(exp_plot.size() > 0 ? exp_plot.pop_front() : 20'hxxxxx, spot.x, spot.y);
      if (char_strobe === 1'b1)
         cmp_val("char", exp_char.size() > 0 ? 20'(exp_char.pop_front()) : 20'hxxxxx, 20'(char_code));
   end

   initial
   begin
      srst = 1'b1;
      clk_en = 1'b1;
      flag_clear = 1'b0;
      pen_sense = 1'b0;
      watch = 1'b1;
      void'($urandom(32'hcdfd0acd));
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      cmp_bit("request", 1'b1, data_request);
      cmp_val("flags", 20'h0, 20'(flags));
      run(fld(MODE_POINT, 4) | b(5) | b(6) | b(11) | fld(1, 13) | b(14) | fld(5, 17), fld(MODE_POINT, 4) | fld(10'h064, 17));
      cmp_bit("settle", 1'b1, lat > SET);
      cmp_val("scale", 20'h1, 20'(spot.scale));
      cmp_val("level", 20'h5, 20'(spot.level));
      cmp_bit("pen enable", 1'b1, pen_enable);
      cmp_val("x", 20'h064, 20'(spot.x));
      cmp_bit("done", 1'b1, flags.done);
      pen_sense <= 1'b1;
      exp_plot.push_back({10'h064, 10'h0c8});
      run(b(1) | fld(MODE_POINT, 4) | b(7) | fld(10'h0c8, 17), fld(MODE_PARAM, 4) | b(5) | fld(10'h12c, 17));
      pen_sense <= 1'b0;
      cmp_bit("settle twice", 1'b1, lat > 2 * SET);
      cmp_bit("pen flag", 1'b1, flags.pen);
      cmp_bit("special", 1'b1, special_irq);
      cmp_bit("pen enable", 1'b0, pen_enable);
      cmp_val("x", 20'h12c, 20'(spot.x));
      cmp_val("y", 20'h0c8, 20'(spot.y));
      flag_clear <= 1'b1;
      @(posedge ref_clk);
      flag_clear <= 1'b0;
      repeat (2) @(posedge ref_clk);
      cmp_bit("pen cleared", 1'b0, flags.pen);
      exp_plot.push_back({10'h12e, 10'h0ca});
      exp_plot.push_back({10'h130, 10'h0ca});
      exp_plot.push_back({10'h130, 10'h0cc});
      run(fld(MODE_INCR, 4) | fld(2, 13) | fld(3, 17), b(1) | fld(4'ha, 5) | fld(4'h8, 9) | fld(4'h2, 17));
      cmp_val("kept scale", 20'h1, 20'(spot.scale));
      cmp_val("kept level", 20'h5, 20'(spot.level));
      run(b(0) | fld(4'h8, 5) | fld(4'h8, 9) | fld(4'h8, 13) | fld(4'h8, 17), b(11));
      cmp_val("x", 20'h138, 20'(spot.x));
      cmp_val("escaped scale", 20'h0, 20'(spot.scale));
      cmp_bit("plots", 1'b1, exp_plot.size() == 0);
      for (int i = 0; i < 4; i++)
      begin
         sc = $urandom % 4;
         lv = $urandom % 8;
         run(b(11) | fld(sc, 13) | b(14) | fld(lv, 17), fld(3 - sc, 13) | fld(7 - lv, 17));
         cmp_val("scale", 20'(sc), 20'(spot.scale));
         cmp_val("level", 20'(lv), 20'(spot.level));
      end
      run(18'h0, fld(MODE_CHAR, 4));
      watch <= 1'b0;
      exp_char.push_back(6'h01);
      exp_char.push_back(6'h02);
      run({6'h01, CH_UPPER, 6'h02}, {CH_SPACE, CH_CR, CH_ESC});
      cmp_bit("upper", 1'b1, upper_case);
      run(b(11) | fld(2, 13), 18'h0);
      cmp_val("scale after escape", 20'h2, 20'(spot.scale));
      cmp_bit("chars", 1'b1, exp_char.size() == 0);
      for (int i = 0; i < 2; i++)
      begin
         i_host_port_model.send({b(7) | (i == 0 ? b(8) : 18'h0), 18'h0});
         repeat (10) @(posedge ref_clk);
         cmp_bit("stop", 1'b1, flags.stop);
         cmp_bit("request held", 1'b0, data_request);
         cmp_bit("stop irq", i == 0, special_irq);
         reinit_check();
      end
      watch <= 1'b1;
      for (int i = 0; i < 6; i++) exp_plot.push_back({10'h3fd + 10'(i % 3), 10'h000});
      run(fld(MODE_POINT, 4) | b(11), fld(MODE_VEC, 4) | fld(10'h3fc, 17));
      i_host_port_model.send({b(1) | fld(7'h07, 9), 18'h0});
      wait_stop();
      cmp_bit("edge", 1'b1, flags.edge_hit);
      cmp_bit("edge irq", 1'b1, special_irq);
      reinit_check();
      run(fld(MODE_POINT, 4), fld(MODE_VCONT, 4) | fld(10'h3fc, 17));
      run(b(1) | fld(7'h01, 9), 18'h0);
      cmp_bit("legal edge", 1'b1, flags.edge_hit);
      cmp_bit("no stop", 1'b0, flags.stop);
      cmp_bit("vector plots", 1'b1, exp_plot.size() == 0);
      run(18'h0, 18'h0);
      cmp_bit("edge cleared", 1'b0, flags.edge_hit);
      complete_run();
   end
endmodule
